//--- iro_defines.svh
// Constants of the serial time code output encoder
`ifndef IRO_DEFINES_SVH
`define IRO_DEFINES_SVH
// Clock and derived timing
`define IRO_CLOCK_HZ          25000000
`define IRO_STEPS_PER_CARRIER 10
`define IRO_STEP_CYCLES(hz)   (`IRO_CLOCK_HZ / ((hz) * `IRO_STEPS_PER_CARRIER))
`define IRO_PPS_PERIOD_S      1
`define IRO_PPS_CYCLES        (`IRO_CLOCK_HZ * `IRO_PPS_PERIOD_S)
`define IRO_CARRIER_A_HZ      10000
`define IRO_CARRIER_B_HZ      1000
`define IRO_CARRIER_E_HZ      100
`define IRO_CARRIER_G_HZ      100000
`define IRO_CARRIER_XR3_HZ    250
`define IRO_STEPS_PER_SLOT    7'h0a
`define IRO_STEPS_PER_SLOT_HI 7'h64
// Frame shape
`define IRO_FRAME_LAST        7'h63
`define IRO_SLOT_LAST         4'h9
`define IRO_WIDTH_ZERO        4'h2
`define IRO_WIDTH_ONE         4'h5
`define IRO_WIDTH_MARK        4'h8
// Field positions
`define IRO_POS_SEC           1
`define IRO_POS_SEC10         6
`define IRO_POS_MIN           10
`define IRO_POS_MIN10         15
`define IRO_POS_HOUR          20
`define IRO_POS_HOUR10        25
`define IRO_POS_DAY           30
`define IRO_POS_DAY10         35
`define IRO_POS_DAY100        40
`define IRO_POS_YEAR          50
`define IRO_POS_YEAR10        55
`define IRO_POS_SBS_LO        80
`define IRO_POS_SBS_HI        90
`define IRO_CF_FIRST          60
`define IRO_CF_SPAN           19
`define IRO_CF_UNLOCK         73
`define IRO_CF_TQ1            75
`define IRO_LCF_FIRST         50
`define IRO_LCF_UNLOCK        53
`define IRO_LCF_TQ1           55
// Quality thresholds in ns
`define IRO_TQ1_NS            32'h0000_03e8
`define IRO_TQ2_NS            32'h0000_2710
`define IRO_TQ3_NS            32'h0001_86a0
`define IRO_TQ4_NS            32'h000f_4240
// Carrier amplitudes, mark about three times space
`define IRO_AM_HI_36          8'h38
`define IRO_AM_HI_72          8'h5b
`define IRO_AM_LO_36          8'h13
`define IRO_AM_LO_72          8'h1e
// Registers
`define IRO_REG_CONFIG        4'h0
`define IRO_REG_STATUS        4'h4
`define IRO_CFG_MOD           4
`define IRO_CFG_E1K           5
`define IRO_CFG_VAR           8
`define IRO_CFG_RESET         11'h201
`endif

//--- iro_pkg.sv
// Types and field helpers of the time code encoder
package iro_pkg;
  typedef enum logic [3:0] {
    IRO_FAM_A, IRO_FAM_B, IRO_FAM_E, IRO_FAM_G, IRO_FAM_B1344,
    IRO_FAM_LEGACY, IRO_FAM_NASA36, IRO_FAM_XR3, IRO_FAM_2137
  } iro_family_type;

  typedef enum {IRO_IDLE, IRO_RUN} iro_state_type;

  function automatic logic iro_is_std(input iro_family_type f);
    iro_is_std = (f == IRO_FAM_A) || (f == IRO_FAM_B) || (f == IRO_FAM_E) ||
                 (f == IRO_FAM_G) || (f == IRO_FAM_B1344);
  endfunction : iro_is_std

  function automatic logic iro_has_cf(input iro_family_type f, input logic [2:0] v);
    iro_has_cf = (f == IRO_FAM_B1344) || (f == IRO_FAM_LEGACY) ||
                 (iro_is_std(f) && !v[1]);
  endfunction : iro_has_cf

  function automatic logic iro_has_yr(input iro_family_type f, input logic [2:0] v);
    iro_has_yr = (f == IRO_FAM_B1344) || (iro_is_std(f) && v[2]);
  endfunction : iro_has_yr

  function automatic logic iro_has_sbs(input iro_family_type f, input logic [2:0] v);
    iro_has_sbs = (f == IRO_FAM_B1344) || (iro_is_std(f) && (v[0] == v[1]));
  endfunction : iro_has_sbs
endpackage : iro_pkg

//--- iro_frame_builder.sv
// Frame content register, loaded at each frame start
`timescale 1ns/100ps
`include "iro_defines.svh"
module iro_frame_builder
  import iro_pkg::*;
(
  // Clock and reset
  input  wire logic           clock_in,
  input  wire logic           rst_n_in,
  // Load request with format
  input  wire logic           load_in,
  input  wire iro_family_type fam_in,
  input  wire logic [2:0]     variant_in,
  // Time of the coming second and flags
  input  wire logic [5:0]     sec_in,
  input  wire logic [5:0]     min_in,
  input  wire logic [4:0]     hour_in,
  input  wire logic [8:0]     day_in,
  input  wire logic [6:0]     year_in,
  input  wire logic           unlocked_in,
  input  wire logic [3:0]     quality_in,
  // Frame bits by position
  output logic [99:0]         frame_out
);

  function automatic logic [3:0] units(input logic [6:0] x);
    units = 4'(x % 7'h0a);
  endfunction : units

  function automatic logic [3:0] tens(input logic [6:0] x);
    tens = 4'(x / 7'h0a);
  endfunction : tens

  wire logic [6:0]  day_rem_w = 7'(day_in % 9'h064);
  wire logic [16:0] sod_w     = 17'(hour_in) * 17'h00e10 + 17'(min_in) * 17'h0003c
                                + 17'(sec_in);
  wire logic        std_w     = iro_is_std(fam_in);
  wire logic        cf_w      = iro_has_cf(fam_in, variant_in);
  logic [99:0]      frame_nxt;

  always_comb begin
    frame_nxt = '0;
    frame_nxt[`IRO_POS_SEC +: 4]    = units(7'(sec_in));
    frame_nxt[`IRO_POS_SEC10 +: 3]  = 3'(tens(7'(sec_in)));
    frame_nxt[`IRO_POS_MIN +: 4]    = units(7'(min_in));
    frame_nxt[`IRO_POS_MIN10 +: 3]  = 3'(tens(7'(min_in)));
    frame_nxt[`IRO_POS_HOUR +: 4]   = units(7'(hour_in));
    frame_nxt[`IRO_POS_HOUR10 +: 2] = 2'(tens(7'(hour_in)));
    frame_nxt[`IRO_POS_DAY +: 4]    = units(day_rem_w);
    frame_nxt[`IRO_POS_DAY10 +: 4]  = tens(day_rem_w);
    frame_nxt[`IRO_POS_DAY100 +: 2] = 2'(day_in / 9'h064);
    if (iro_has_yr(fam_in, variant_in)) begin
      frame_nxt[`IRO_POS_YEAR +: 4]   = units(year_in);
      frame_nxt[`IRO_POS_YEAR10 +: 4] = tens(year_in);
    end
    // Other control positions stay zero
    if (cf_w && std_w) begin
      frame_nxt[`IRO_CF_UNLOCK]   = unlocked_in;
      frame_nxt[`IRO_CF_TQ1 +: 4] = quality_in;
    end
    if (cf_w && !std_w) begin
      frame_nxt[`IRO_LCF_UNLOCK]   = unlocked_in;
      frame_nxt[`IRO_LCF_TQ1 +: 4] = quality_in;
    end
    if (iro_has_sbs(fam_in, variant_in)) begin
      frame_nxt[`IRO_POS_SBS_LO +: 9] = sod_w[8:0];
      frame_nxt[`IRO_POS_SBS_HI +: 8] = sod_w[16:9];
    end
  end

  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      frame_out <= '0;
    end else if (load_in) begin
      frame_out <= frame_nxt;
    end
  end
endmodule : iro_frame_builder

//--- iro_timecode_encoder.sv
// Serial time code output encoder: framing, symbols, carrier, second pulse
//
// Function
// - Emit the configured format; a new choice takes effect at next frame.
// - Drive level-shifted stream or modulated carrier as the format says.
// - IRIG A: level codes 000-007, 10 kHz codes 130-137, fields by name.
// - IRIG B: level 000-007, 1 kHz 120-127, plus 1344 both forms.
// - IRIG E: level 001/002/005/006, 100 Hz and 1 kHz carrier codes.
// - IRIG G: only level 005 and 100 kHz 145, year and control.
// - Legacy B and NASA 36 both forms, XR3 at 250 Hz, 2137 level.
// - Unlock and quality flags are active high.
// - Control positions 70, 71, 72, 74 are zero.
// - Position 73 set while unit is not locked.
// - Position 75 for error over 1 us, 76 over 10 us.
// - Position 77 for error over 100 us, 78 over 1 ms.
// - Legacy B: positions 50-52 zero, 53 unlock.
// - Legacy B: 54 zero, quality flags at 55-58.
// - Second pulse on hardware clock, rising on time, half duty.
//
// The implementer's own choices: the register addresses and the plain strobed port.
`timescale 1ns/100ps
`include "iro_defines.svh"
module iro_timecode_encoder
  import iro_pkg::*;
#(
  parameter int A_STEP_CYCLES   = `IRO_STEP_CYCLES(`IRO_CARRIER_A_HZ),
  parameter int B_STEP_CYCLES   = `IRO_STEP_CYCLES(`IRO_CARRIER_B_HZ),
  parameter int E_STEP_CYCLES   = `IRO_STEP_CYCLES(`IRO_CARRIER_E_HZ),
  parameter int G_STEP_CYCLES   = `IRO_STEP_CYCLES(`IRO_CARRIER_G_HZ),
  parameter int XR3_STEP_CYCLES = `IRO_STEP_CYCLES(`IRO_CARRIER_XR3_HZ),
  parameter int PPS_CYCLES      = `IRO_PPS_CYCLES
) (
  // Clock and reset
  input  wire logic        clock_in,
  input  wire logic        rst_n_in,
  // Register port
  input  wire logic [3:0]  reg_addr_in,
  input  wire logic [31:0] reg_wdata_in,
  input  wire logic        reg_wr_in,
  input  wire logic        reg_rd_in,
  output logic [31:0]      reg_rdata_out,
  // Hardware clock time of the coming second
  input  wire logic [5:0]  sec_in,
  input  wire logic [5:0]  min_in,
  input  wire logic [4:0]  hour_in,
  input  wire logic [8:0]  day_in,
  input  wire logic [6:0]  year_in,
  input  wire logic        locked_in,
  input  wire logic [31:0] error_ns_in,
  // Time code outputs
  output logic             level_shifted_output_out,
  output logic [7:0]       am_sample_out,
  output logic             second_pulse_output_out
);

  ////////////////////////////////////////////////////////////////////////////
  // Parameter checks
  if (A_STEP_CYCLES < 1 || B_STEP_CYCLES < 1 || E_STEP_CYCLES < 1 ||
      G_STEP_CYCLES < 1 || XR3_STEP_CYCLES < 1 ||
      E_STEP_CYCLES >= (1 << 24) || XR3_STEP_CYCLES >= (1 << 24) ||
      PPS_CYCLES < 16 || PPS_CYCLES >= (1 << 26)) begin : g_bad_param
    $error("iro_timecode_encoder: unsupported timing parameter");
  end

  localparam logic [25:0] PPS_LAST = 26'(PPS_CYCLES - 1);
  localparam logic [25:0] PPS_HALF = 26'(PPS_CYCLES / 2);

  ////////////////////////////////////////////////////////////////////////////
  // Helpers
  function automatic logic cfg_ok(input logic [10:0] c);
    logic [2:0] v;
    logic       am;
    logic       e1k;
    v   = c[`IRO_CFG_VAR +: 3];
    am  = c[`IRO_CFG_MOD];
    e1k = c[`IRO_CFG_E1K];
    cfg_ok = 1'b0;
    if (c[7:6] == 2'h0 && (!e1k || (am && c[3:0] == 4'(IRO_FAM_E)))) begin
      case (c[3:0])
        4'(IRO_FAM_A), 4'(IRO_FAM_B): cfg_ok = 1'b1;
        4'(IRO_FAM_E):      cfg_ok = (v[1] != v[0]);
        4'(IRO_FAM_G):      cfg_ok = (v == 3'h5);
        4'(IRO_FAM_B1344),
        4'(IRO_FAM_LEGACY),
        4'(IRO_FAM_NASA36): cfg_ok = (v == 3'h0);
        4'(IRO_FAM_XR3):    cfg_ok = (v == 3'h0) && am;
        4'(IRO_FAM_2137):   cfg_ok = (v == 3'h0) && !am;
        default:            cfg_ok = 1'b0;
      endcase
    end
  endfunction : cfg_ok

  // Carrier step length per family; E may run its 1 kHz carrier
  function automatic logic [23:0] step_cycles(input iro_family_type f,
                                              input logic e1k);
    case (f)
      IRO_FAM_A:   step_cycles = 24'(A_STEP_CYCLES);
      IRO_FAM_E:   step_cycles = e1k ? 24'(B_STEP_CYCLES) : 24'(E_STEP_CYCLES);
      IRO_FAM_G:   step_cycles = 24'(G_STEP_CYCLES);
      IRO_FAM_XR3: step_cycles = 24'(XR3_STEP_CYCLES);
      default:     step_cycles = 24'(B_STEP_CYCLES);
    endcase
  endfunction : step_cycles

  // Ten-step sine, mark or space amplitude
  function automatic logic [7:0] sine(input logic [3:0] ph, input logic mark);
    logic [7:0] mag;
    mag = 8'h00;
    case (ph)
      4'h1, 4'h4, 4'h6, 4'h9: mag = mark ? `IRO_AM_HI_36 : `IRO_AM_LO_36;
      4'h2, 4'h3, 4'h7, 4'h8: mag = mark ? `IRO_AM_HI_72 : `IRO_AM_LO_72;
      default:                mag = 8'h00;
    endcase
    sine = (ph > 4'h4) ? 8'(~mag + 8'h01) : mag;
  endfunction : sine

  ////////////////////////////////////////////////////////////////////////////
  // State
  logic [10:0]   cfg_r;
  logic [10:0]   act_cfg_r;
  logic          rejected_r;
  iro_state_type state_r;
  logic [25:0]   pps_cnt_r;
  logic [23:0]   div_cnt_r;
  logic [6:0]    step_r;
  logic [3:0]    slot_r;
  logic [6:0]    pos_r;
  logic [3:0]    phase_r;
  logic [99:0]   frame_w;

  ////////////////////////////////////////////////////////////////////////////
  // Decode
  wire iro_family_type act_fam_w = iro_family_type'(act_cfg_r[3:0]);
  wire iro_family_type cfg_fam_w = iro_family_type'(cfg_r[3:0]);
  wire logic [2:0]  cfg_var_w   = cfg_r[`IRO_CFG_VAR +: 3];
  wire logic        act_mod_w   = act_cfg_r[`IRO_CFG_MOD];
  wire logic        act_e1k_w   = act_cfg_r[`IRO_CFG_E1K];
  wire logic        running_w   = (state_r == IRO_RUN);
  wire logic [23:0] step_len_w  = step_cycles(act_fam_w, act_e1k_w);
  wire logic [6:0]  slot_len_w  = (act_fam_w == IRO_FAM_E && act_e1k_w) ?
                                  `IRO_STEPS_PER_SLOT_HI : `IRO_STEPS_PER_SLOT;
  wire logic        sec_tick_w  = (pps_cnt_r == PPS_LAST);
  wire logic        step_tick_w = running_w && (div_cnt_r == step_len_w - 24'h000001);
  wire logic        slot_tick_w = step_tick_w && (step_r == slot_len_w - 7'h01);
  wire logic        pos_tick_w  = slot_tick_w && (slot_r == `IRO_SLOT_LAST);
  wire logic        frame_end_w = pos_tick_w && (pos_r == `IRO_FRAME_LAST);
  // A and G fit several frames into one second; a switch away waits for the tick
  wire logic        multi_w     = (act_fam_w == IRO_FAM_A || act_fam_w == IRO_FAM_G) &&
                                  (cfg_fam_w == IRO_FAM_A || cfg_fam_w == IRO_FAM_G);
  wire logic        start_w     = (sec_tick_w && (!running_w || frame_end_w)) ||
                                  (frame_end_w && multi_w);
  wire logic        marker_w    = (pos_r == 7'h00) || (pos_r % 7'h0a == 7'h09);
  wire logic [3:0]  width_w     = marker_w ? `IRO_WIDTH_MARK :
                                  frame_w[pos_r] ? `IRO_WIDTH_ONE : `IRO_WIDTH_ZERO;
  wire logic        level_w     = running_w && (slot_r < width_w);
  wire logic [3:0]  quality_w   = {error_ns_in > `IRO_TQ4_NS, error_ns_in > `IRO_TQ3_NS,
                                   error_ns_in > `IRO_TQ2_NS, error_ns_in > `IRO_TQ1_NS};
  wire logic        cfg_wr_w    = reg_wr_in && (reg_addr_in == `IRO_REG_CONFIG);
  wire logic        cfg_good_w  = cfg_ok(reg_wdata_in[10:0]) && (reg_wdata_in[31:11] == '0);
  wire logic [31:0] status_w    = {14'h0000, quality_w, !locked_in, running_w,
                                   rejected_r, act_cfg_r};
  wire logic [31:0] rdata_nxt   = !reg_rd_in ? 32'h0000_0000 :
                                  (reg_addr_in == `IRO_REG_CONFIG) ? {21'h000000, cfg_r} :
                                  (reg_addr_in == `IRO_REG_STATUS) ? status_w : 32'h0000_0000;

  ////////////////////////////////////////////////////////////////////////////
  // Configuration; invalid codes are refused and flagged
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      cfg_r      <= `IRO_CFG_RESET;
      rejected_r <= 1'b0;
    end else if (cfg_wr_w) begin
      cfg_r      <= cfg_good_w ? reg_wdata_in[10:0] : cfg_r;
      rejected_r <= !cfg_good_w;
    end
  end

  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      reg_rdata_out <= 32'h0000_0000;
    end else begin
      reg_rdata_out <= rdata_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Second counter
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      pps_cnt_r <= 26'h0000000;
    end else begin
      pps_cnt_r <= sec_tick_w ? 26'h0000000 : pps_cnt_r + 26'h0000001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Frame sequencer
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      state_r   <= IRO_IDLE;
      act_cfg_r <= `IRO_CFG_RESET;
    end else if (start_w) begin
      state_r   <= IRO_RUN;
      act_cfg_r <= cfg_r;
    end else if (frame_end_w) begin
      state_r   <= IRO_IDLE;
    end
  end

  always_ff @(posedge clock_in) begin
    if (!rst_n_in || start_w) begin
      div_cnt_r <= 24'h000000;
      step_r    <= 7'h00;
      slot_r    <= 4'h0;
      pos_r     <= 7'h00;
      phase_r   <= 4'h0;
    end else if (step_tick_w) begin
      div_cnt_r <= 24'h000000;
      step_r    <= slot_tick_w ? 7'h00 : step_r + 7'h01;
      slot_r    <= pos_tick_w ? 4'h0 : slot_tick_w ? slot_r + 4'h1 : slot_r;
      pos_r     <= pos_tick_w ? pos_r + 7'h01 : pos_r;
      phase_r   <= (phase_r == 4'h9) ? 4'h0 : phase_r + 4'h1;
    end else if (running_w) begin
      div_cnt_r <= div_cnt_r + 24'h000001;
    end
  end

  iro_frame_builder u_frame (
    .clock_in    (clock_in),
    .rst_n_in    (rst_n_in),
    .load_in     (start_w),
    .fam_in      (cfg_fam_w),
    .variant_in  (cfg_var_w),
    .sec_in      (sec_in),
    .min_in      (min_in),
    .hour_in     (hour_in),
    .day_in      (day_in),
    .year_in     (year_in),
    .unlocked_in (!locked_in),
    .quality_in  (quality_w),
    .frame_out   (frame_w)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Outputs; pulse and symbols both lag their counters one cycle
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      second_pulse_output_out  <= 1'b0;
      level_shifted_output_out <= 1'b0;
      am_sample_out            <= 8'h00;
    end else begin
      second_pulse_output_out  <= (pps_cnt_r < PPS_HALF);
      level_shifted_output_out <= !act_mod_w && level_w;
      am_sample_out <= (act_mod_w && running_w) ? sine(phase_r, level_w) : 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  wire logic std_cf_w = iro_is_std(cfg_fam_w) && iro_has_cf(cfg_fam_w, cfg_var_w);

  property p_cfg_apply;
    @(posedge clock_in) disable iff (!rst_n_in)
    start_w |=> (act_cfg_r == $past(cfg_r)) && running_w;
  endproperty
  a_cfg_apply: assert property (p_cfg_apply) else $error("format not applied");

  property p_cfg_legal;
    @(posedge clock_in) disable iff (!rst_n_in)
    (cfg_wr_w && !cfg_good_w) |=> rejected_r && (cfg_r == $past(cfg_r));
  endproperty
  a_cfg_legal: assert property (p_cfg_legal) else $error("bad format taken");

  property p_mode_level;
    @(posedge clock_in) disable iff (!rst_n_in)
    act_mod_w |=> !level_shifted_output_out;
  endproperty
  a_mode_level: assert property (p_mode_level) else $error("level on carrier");

  property p_mode_am;
    @(posedge clock_in) disable iff (!rst_n_in)
    !act_mod_w |=> (am_sample_out == 8'h00);
  endproperty
  a_mode_am: assert property (p_mode_am) else $error("carrier on level");

  property p_cf_zero;
    @(posedge clock_in) disable iff (!rst_n_in)
    (start_w && std_cf_w) |=> (frame_w[`IRO_CF_UNLOCK - 1 -: 3] == 3'h0) &&
                              !frame_w[`IRO_CF_UNLOCK + 1];
  endproperty
  a_cf_zero: assert property (p_cf_zero) else $error("reserved cf set");

  property p_unlock;
    @(posedge clock_in) disable iff (!rst_n_in)
    (start_w && std_cf_w) |=> frame_w[`IRO_CF_UNLOCK] == !$past(locked_in);
  endproperty
  a_unlock: assert property (p_unlock) else $error("unlock flag wrong");

  property p_quality;
    @(posedge clock_in) disable iff (!rst_n_in)
    (start_w && std_cf_w) |=> (frame_w[`IRO_CF_TQ1 +: 4] == $past(quality_w)) &&
                              ($past(error_ns_in) > `IRO_TQ1_NS) == frame_w[`IRO_CF_TQ1];
  endproperty
  a_quality: assert property (p_quality) else $error("quality flags wrong");

  property p_legacy;
    @(posedge clock_in) disable iff (!rst_n_in)
    (start_w && cfg_fam_w == IRO_FAM_LEGACY) |=>
      (frame_w[`IRO_LCF_FIRST +: 5] == {1'b0, !$past(locked_in), 3'h0}) &&
      (frame_w[`IRO_LCF_TQ1 +: 4] == $past(quality_w));
  endproperty
  a_legacy: assert property (p_legacy) else $error("legacy cf wrong");

  property p_no_cf;
    @(posedge clock_in) disable iff (!rst_n_in)
    (start_w && !iro_has_cf(cfg_fam_w, cfg_var_w)) |=>
      (frame_w[`IRO_CF_FIRST +: `IRO_CF_SPAN] == '0);
  endproperty
  a_no_cf: assert property (p_no_cf) else $error("cf without field");

  property p_pps_edge;
    @(posedge clock_in) disable iff (!rst_n_in)
    $rose(second_pulse_output_out) |-> ($past(pps_cnt_r) == 26'h0000000) ##1
      second_pulse_output_out[*7];
  endproperty
  a_pps_edge: assert property (p_pps_edge) else $error("second pulse off time");

  property p_frame_sec;
    @(posedge clock_in) disable iff (!rst_n_in)
    (running_w && !$past(running_w)) |-> $past(sec_tick_w) ##1 second_pulse_output_out;
  endproperty
  a_frame_sec: assert property (p_frame_sec) else $error("frame off second");
endmodule : iro_timecode_encoder

//--- iro_decoder_model.sv
// Far-side decoder of the level-shifted code and second pulse
`timescale 1ns/100ps
module iro_decoder_model #(
  parameter int SLOT = 10
) (
  // Clock
  input  wire logic        clock_in,
  // Encoder outputs
  input  wire logic        level_in,
  input  wire logic [7:0]  am_in,
  input  wire logic        pulse_in,
  // Last complete frame
  output logic [99:0]      frame_bits_out = '0,
  output logic [7:0]       cells_out = 8'h00,
  output logic             am_seen_out = 1'b0,
  output logic [31:0]      pulse_len_out = 32'h0
);
  logic [99:0] bits = '0;
  logic [7:0]  cells = 8'h00;
  logic [31:0] hi = 32'h0;
  logic [31:0] p_len = 32'h0;
  logic        am_any = 1'b0;
  logic        p_q = 1'b0;
  logic        l_q = 1'b0;
  // Frame boundary taken from the pulse rise, not from markers
  always @(posedge clock_in) begin
    if (pulse_in && !p_q) begin
      frame_bits_out = bits;
      cells_out = cells;
      am_seen_out = am_any;
      cells = 8'h00;
      am_any = 1'b0;
    end
    if (!pulse_in && p_q)
      pulse_len_out = p_len;
    p_len = pulse_in ? p_len + 1 : 32'h0;
    if (am_in !== 8'h00)
      am_any = 1'b1;
    // High width 2, 5 or 8 slots: zero, one, marker
    if (!level_in && l_q && cells < 8'd100) begin
      bits[cells] = (hi > 3 * SLOT) && (hi < 7 * SLOT);
      cells = cells + 8'd1;
    end
    hi = level_in ? hi + 1 : 32'h0;
    p_q = pulse_in;
    l_q = level_in;
  end
endmodule : iro_decoder_model

//--- iro_timecode_encoder_tb_top.sv
// Testbench of the time code encoder: registers, frames, second pulse
`timescale 1ns/100ps
module iro_timecode_encoder_tb_top;
  import iro_pkg::*;
  localparam int PPS = 10000;
  // Format codes, refusal expected in the top bit
  localparam logic [11:0] CFG_TAB [10] = '{12'h812, 12'h132, 12'hc13, 12'h503, 12'h807,
                                           12'h017, 12'h818, 12'h008, 12'h831, 12'h710};
  logic        clock_in, rst_n_in, reg_wr_in, reg_rd_in, locked_in, lvl, pps, am_seen;
  logic [3:0]  reg_addr_in;
  logic [31:0] reg_wdata_in, reg_rdata_out, error_ns_in, rd_d, seed, pl;
  logic [5:0]  sec_in, min_in;
  logic [4:0]  hour_in;
  logic [8:0]  day_in;
  logic [6:0]  year_in;
  logic [7:0]  am, cells;
  logic [99:0] fb;
  logic [6:0]  t_sec [1:5], t_min [1:5], t_hour [1:5], t_year [1:5];
  logic [31:0] t_e [1:5];
  logic        t_lk [1:5];
  int          n_mismatch, n_checks;
  ////////////////////////////////////////////////////////////////////////////////
  // Short step keeps a second at 10000 cycles with aligned B frames
  iro_timecode_encoder #(.B_STEP_CYCLES(1), .PPS_CYCLES(PPS)) dut_u (
    .clock_in(clock_in), .rst_n_in(rst_n_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_rdata_out(reg_rdata_out), .sec_in(sec_in), .min_in(min_in), .hour_in(hour_in),
    .day_in(day_in), .year_in(year_in), .locked_in(locked_in), .error_ns_in(error_ns_in),
    .level_shifted_output_out(lvl), .am_sample_out(am), .second_pulse_output_out(pps));
  iro_decoder_model #(.SLOT(10)) far_u (.clock_in(clock_in), .level_in(lvl), .am_in(am),
    .pulse_in(pps), .frame_bits_out(fb), .cells_out(cells), .am_seen_out(am_seen),
    .pulse_len_out(pl));
  initial begin
    clock_in = 1'b0;
    forever #20 clock_in = ~clock_in;
  end
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    xs = x ^ (x << 5);
  endfunction : xs
  function automatic logic [3:0] qual(input logic [31:0] e);
    qual = {e > 32'd1000000, e > 32'd100000, e > 32'd10000, e > 32'd1000};
  endfunction : qual
  function automatic logic [31:0] bcd(input logic [6:0] v);
    bcd = {24'h0, 4'(v / 7'd10), 4'(v % 7'd10)};
  endfunction : bcd
  task check(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : report_and_stop
  task wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clock_in);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_wr_in <= 1'b1;
    @(posedge clock_in);
    reg_wr_in <= 1'b0;
  endtask : wr
  task rd(input logic [3:0] a);
    @(posedge clock_in);
    reg_addr_in <= a;
    reg_rd_in <= 1'b1;
    @(posedge clock_in);
    reg_rd_in <= 1'b0;
    #1 rd_d = reg_rdata_out;
  endtask : rd
  // Time and flags for frame k, taken at the coming second tick
  task set_frame(input int k, input logic [10:0] cfg, input logic lk, input logic [31:0] e);
    seed = xs(seed);
    t_sec[k] = 7'(seed % 60);
    t_min[k] = 7'((seed >> 8) % 60);
    t_hour[k] = 7'((seed >> 16) % 24);
    t_year[k] = 7'((seed >> 20) % 100);
    t_lk[k] = lk;
    t_e[k] = e;
    @(posedge clock_in);
    sec_in <= t_sec[k][5:0];
    min_in <= t_min[k][5:0];
    hour_in <= t_hour[k][4:0];
    day_in <= 9'(1 + (seed >> 3) % 366);
    year_in <= t_year[k];
    locked_in <= lk;
    error_ns_in <= e;
    wr(4'h0, {21'h0, cfg});
  endtask : set_frame
  task next_second;
    int   i;
    logic prev;
    for (i = 0; i < PPS + 50; i++) begin
      prev = pps;
      @(posedge clock_in);
      #1;
      if (pps === 1'b1 && prev === 1'b0)
        break;
    end
    if (i >= PPS + 50) begin
      n_mismatch++;
      report_and_stop();
    end
    repeat (2) @(posedge clock_in);
    #1;
  endtask : next_second
  // Kind 0 standard with year, control and seconds of day; 1 legacy; 2 no control
  task check_frame(input int k, input int kind);
    logic [3:0]  q;
    logic [31:0] s;
    q = qual(t_e[k]);
    s = t_sec[k] + 60 * t_min[k] + 3600 * t_hour[k];
    check({24'h0, cells}, 32'd100);
    check({25'h0, fb[8:6], fb[4:1]}, bcd(t_sec[k]));
    if (kind == 0) begin
      check({13'h0, fb[78:60]}, {13'h0, q, 1'b0, !t_lk[k], 13'h0});
      check({24'h0, fb[58:55], fb[53:50]}, bcd(t_year[k]));
      check({15'h0, fb[97:90], fb[88:80]}, s);
    end else if (kind == 1)
      check({23'h0, fb[58:50]}, {23'h0, q, 1'b0, !t_lk[k], 3'h0});
    else
      check({13'h0, fb[78:60]}, 32'h0);
  endtask : check_frame
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    seed = 32'hc8b912ac;
    {rst_n_in, reg_wr_in, reg_rd_in, locked_in, reg_addr_in, reg_wdata_in} = '0;
    {sec_in, min_in, hour_in, day_in, year_in, error_ns_in} = '0;
    repeat (4) @(posedge clock_in);
    rst_n_in <= 1'b1;
    rd(4'h0);
    check(rd_d, 32'h201);
    @(posedge clock_in);
    #1 check(reg_rdata_out, 32'h0);
    wr(4'h0, 32'h9);
    rd(4'h0);
    check(rd_d, 32'h201);
    rd(4'h4);
    check({31'h0, rd_d[11]}, 32'h1);
    rd(4'h8);
    check(rd_d, 32'h0);
    for (int i = 0; i < 10; i++) begin
      wr(4'h0, {21'h0, CFG_TAB[i][10:0]});
      rd(4'h4);
      check({31'h0, rd_d[11]}, {31'h0, CFG_TAB[i][11]});
    end
    seed = xs(seed);
    set_frame(1, 11'h401, 1'b0, (seed & 32'h00ff_ffff) | 32'h0010_0000);
    rd(4'h4);
    check({31'h0, rd_d[11]}, 32'h0);
    next_second();
    set_frame(2, 11'h005, 1'b1, 32'd10000);
    rd(4'h4);
    check(rd_d, 32'h0000_5401);
    next_second();
    check_frame(1, 0);
    set_frame(3, 11'h201, 1'b0, 32'hffff_ffff);
    next_second();
    check_frame(2, 1);
    set_frame(4, 11'h011, 1'b1, 32'h0);
    next_second();
    check_frame(3, 2);
    check({31'h0, am_seen}, 32'h0);
    check(pl, PPS / 2);
    set_frame(5, 11'h201, 1'b1, 32'h0);
    next_second();
    check({24'h0, cells}, 32'h0);
    check({31'h0, am_seen}, 32'h1);
    report_and_stop();
  end
endmodule : iro_timecode_encoder_tb_top
